/* File: verilog/qbp_pkg.sv */
// qbp_pkg: shared constants for the quasi-bidirectional port block
package qbp_pkg;
    localparam int unsigned PORT_W     = 8;          // bits per port
    localparam int unsigned PORT_N     = 4;          // ports 0..3
    localparam int unsigned PINS_W     = 32;         // all pins, flat
    localparam int unsigned OSC_NS     = 50;         // one phase, ns
    localparam int unsigned CYCLE_NS   = 600;        // machine cycle, ns
    // phases per machine cycle, derived from times and clock rate
    localparam int unsigned MC_LEN     = CYCLE_NS / OSC_NS;
    localparam logic [3:0]  SLOT_LAST  = 4'(MC_LEN - 1);
    localparam logic [3:0]  SLOT_STATE1_PHASE1  = 4'h0;       // state1_phase1
    localparam logic [3:0]  SLOT_STATE1_PHASE2  = 4'h1;       // state1_phase2
    localparam logic [3:0]  SLOT_STATE6_PHASE2  = 4'hB;       // state6_phase2
    localparam logic [3:0]  SLOT_RST   = 4'h0;       // slot after reset
    localparam logic [7:0]  LATCH_RST  = 8'hFF;      // latch reset value
    localparam logic [31:0] ALL_ONES   = 32'hFFFFFFFF;
    localparam logic [1:0]  PORT_ZERO  = 2'h0;
    localparam logic [1:0]  PORT_ONE   = 2'h1;
    localparam logic [1:0]  PORT_TWO   = 2'h2;
    localparam logic [1:0]  PORT_THREE = 2'h3;
    // kind of latch write the core delivers
    typedef enum logic [1:0] {
        QBP_WR_BYTE = 2'b01,
        QBP_WR_BIT  = 2'b10
    } qbp_wr_kind_t;
endpackage

/* File: verilog/qbp_tick_if.sv */
// qbp_tick_if: machine-cycle timing strobes passed to the port logic
`timescale 1ns/1ps
interface qbp_tick_if;
    logic phase1;      // high in every phase-1 period
    logic state1_phase1;        // one pulse in state1_phase1
    logic state1_phase2;        // one pulse in state1_phase2
    logic state6_phase2;        // one pulse in state6_phase2
    modport src (output phase1, output state1_phase1, output state1_phase2, output state6_phase2);
    modport dst (input phase1, input state1_phase1, input state1_phase2, input state6_phase2);
endinterface

/* File: verilog/qbp_timing.sv */
// qbp_timing: twelve-phase machine-cycle counter and its strobes
`timescale 1ns/1ps
module qbp_timing
    import qbp_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    qbp_tick_if.src   tick
);
    logic [3:0] slot;       // current phase within the machine cycle
    logic [3:0] next_slot;

    // advance one phase per clock, wrap after state 6 phase 2
    always_comb begin
        if (slot == SLOT_LAST) begin
            next_slot = SLOT_STATE1_PHASE1;
        end else begin
            next_slot = slot + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            slot <= SLOT_RST;
        end else begin
            slot <= next_slot;
        end
    end

    // even slots are phase 1, odd slots phase 2
    assign tick.phase1 = ~slot[0];
    assign tick.state1_phase1   = (slot == SLOT_STATE1_PHASE1);
    assign tick.state1_phase2   = (slot == SLOT_STATE1_PHASE2);
    assign tick.state6_phase2   = (slot == SLOT_STATE6_PHASE2);
endmodule

/* File: verilog/qbp_port_top.sv */
// qbp_port_top: four 8-bit port latches, drivers and read paths
//
// Contract
// - external access: port two kept, port zero ones
// - ports zero/two switch to address bus
// - port three latch one: pin follows alternate
// - port three pin level feeds alternate input
// - ports one to three pull up internally
// - port zero pull-up only emitting bus ones
// - port zero open drain as plain port
// - reset sets all latch bits to one
// - latch written at state six phase two
// - buffers sample latch in phase one only
// - rising latch gives two-phase strong pull-up
// - pulse sets keeper; low pin clears it
// - port two strong pull-up on address ones
// - rmw reads latch, other reads pin
// - destination port operands read the latch
// - bit writes rewrite whole byte from latch
// - port three latch zero forces pin low
// - short address: port two shows latch
`timescale 1ns/1ps
module qbp_port_top
    import qbp_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 wr_en,
    input  wire qbp_pkg::qbp_wr_kind_t wr_kind,
    input  wire logic [1:0]           wr_port,
    input  wire logic [7:0]           wr_data,
    input  wire logic [2:0]           wr_bit,
    input  wire logic                 wr_bit_val,
    output      logic                 wr_ready,
    input  wire logic                 rd_en,
    input  wire logic [1:0]           rd_port,
    input  wire logic                 rd_latch,
    output      logic [7:0]           rd_data,
    input  wire logic                 ext_active,
    input  wire logic                 ext_addr16,
    input  wire logic [7:0]           ext_addr_hi,
    input  wire logic [7:0]           ext_ad_out,
    input  wire logic                 ext_ad_oe,
    output      logic [7:0]           ext_ad_in,
    input  wire logic [7:0]           alt_out,
    output      logic [7:0]           alt_in,
    input  wire logic [31:0]          pin_i,
    output      logic [31:0]          pin_o,
    output      logic [31:0]          pin_oe,
    output      logic [31:0]          pu_keep,
    output      logic [31:0]          pu_weak
);
    import qbp_pkg::*;

    // all 32-bit vectors below are flat: port p, bit b sits at 8*p+b,
    // so port zero is [7:0], port two [23:16] and port three [31:24];
    // one flat map keeps the per-pin driver logic free of port muxes
    qbp_tick_if tick ();                 // timing strobes

    logic [31:0] port_latch;             // the four port latches
    logic [31:0] next_port_latch;
    logic [31:0] out_buf;                // output buffer samples
    logic [31:0] next_out_buf;
    logic [31:0] rise_pulse;             // strong pull-up pulse per bit
    logic [31:0] next_rise_pulse;
    logic [31:0] keeper;                 // weak pull-up keeper latches
    logic [31:0] next_keeper;
    logic [31:0] pin_meta;               // synchroniser first stage
    logic [31:0] pin_sync;               // synchroniser second stage
    logic [7:0]  next_rd_data;
    logic [7:0]  next_alt_in;
    logic [7:0]  next_ext_ad_in;
    logic [7:0]  sel_byte;               // latch byte of wr_port
    logic [7:0]  mod_byte;               // byte after bit modify
    logic        bus_hi;                 // port two carries address
    logic [31:0] drive_low;              // nfet on per pin
    logic [31:0] drive_high;             // strong pull-up per pin

    // phase and state strobes come from the cycle counter;
    // this counter is the only divider: slower rates are one-clock
    // strobes, so every flop below runs on clk alone
    qbp_timing u_timing (
        .clk  (clk),
        .nrst (nrst),
        .tick (tick)
    );

    // the core may present a write at any time; it lands on state6_phase2.
    // the core must hold wr_en until this strobe, or the write is lost
    // (there is no queue: one write per machine cycle at most)
    assign wr_ready = tick.state6_phase2;

    // pin synchroniser: first stage feeds only the second stage;
    // it resets to ones so no false low clears a keeper after reset,
    // at the price of two clocks of lag on every pin read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_meta <= ALL_ONES;
            pin_sync <= ALL_ONES;
        end else begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
        end
    end

    // latch update: core writes on state6_phase2, bus cycles overwrite port 0.
    // the modified byte is formed every cycle from the latch, never from
    // the pins, so a loaded pin cannot corrupt the untouched bits
    always_comb begin
        next_port_latch = port_latch;
        sel_byte        = port_latch[wr_port*8 +: 8];
        mod_byte        = sel_byte;
        mod_byte[wr_bit] = wr_bit_val;
        if (wr_en && tick.state6_phase2) begin
            unique case (wr_kind)
                QBP_WR_BYTE: begin
                    next_port_latch[wr_port*8 +: 8] = wr_data;
                end
                QBP_WR_BIT: begin
                    // whole byte goes back, only one bit differs
                    next_port_latch[wr_port*8 +: 8] = mod_byte;
                end
                default: begin
                    // illegal kind code: latch left as it is
                    next_port_latch = port_latch;
                end
            endcase
        end
        // bus cycle wins over a core write to port 0; port 2 untouched;
        // ones are forced on every clock of the access, so a core write
        // taken in the middle of it cannot leave a stale byte behind
        if (ext_active) begin
            next_port_latch[7:0] = LATCH_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            port_latch <= {PORT_N{LATCH_RST}};
        end else begin
            port_latch <= next_port_latch;
        end
    end

    // output buffers copy the latch in phase 1 and hold through phase 2;
    // the copy is taken at the edge ending each phase-1 period, so a
    // pin moves two clocks after the strobe; the pulse follows it
    always_comb begin
        next_out_buf    = out_buf;
        next_rise_pulse = rise_pulse;
        if (tick.phase1) begin
            next_out_buf = port_latch;
        end
        if (tick.state1_phase1) begin
            // rise seen when the new value first reaches the buffer;
            // port 0 has no pull-up, so it never pulses
            next_rise_pulse = port_latch & ~out_buf;
            next_rise_pulse[7:0] = 8'h00;
        end else if (!tick.state1_phase2) begin
            // pulse lasts exactly the state1_phase2 and state 2 phase 1 periods
            next_rise_pulse = 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_buf    <= {PORT_N{LATCH_RST}};
            rise_pulse <= 32'h00000000;
        end else begin
            out_buf    <= next_out_buf;
            rise_pulse <= next_rise_pulse;
        end
    end

    // keeper: set by the pulse, lost when the pin is seen low;
    // limitation: a low shorter than one clock may slip past the
    // synchroniser and leave the keeper on
    always_comb begin
        next_keeper = keeper;
        for (int i = 0; i < PINS_W; i++) begin
            if (rise_pulse[i]) begin
                // set wins over a low seen in the same cycle
                next_keeper[i] = 1'b1;
            end else if (!pin_sync[i]) begin
                next_keeper[i] = 1'b0;
            end
        end
        next_keeper[7:0] = 8'h00;  // port 0 has no keeper
    end

    // keepers start on: reset leaves latches high and pins pulled up
    always_ff @(posedge clk) begin
        if (!nrst) begin
            keeper <= {ALL_ONES[31:8], 8'h00};
        end else begin
            keeper <= next_keeper;
        end
    end

    // port two carries address only on 16-bit external accesses
    assign bus_hi = ext_active && ext_addr16;

    // per-pin driver choice: low nfet, strong high, or released
    always_comb begin
        drive_low  = ~out_buf;               // latch zero pulls down
        drive_high = rise_pulse;
        // port 0: open drain as a plain port, no pull-up
        drive_high[7:0] = 8'h00;
        if (ext_active) begin
            if (ext_ad_oe) begin
                // both fets follow the address/data byte
                drive_low[7:0]  = ~ext_ad_out;
                drive_high[7:0] = ext_ad_out;
            end else begin
                // read phase: port 0 floats to accept data
                drive_low[7:0]  = 8'h00;
            end
        end
        if (bus_hi) begin
            // strong pull-up held for every address one bit
            // port two is bits 23:16; its latch stays out of the way
            drive_low[23:16]  = ~ext_addr_hi;
            drive_high[23:16] = ext_addr_hi;
        end
        // port 3: a latch one hands the pin to the alternate output,
        // a latch zero holds the pin low whatever it asks;
        // like the port bits, a one only releases the nfet and lets
        // the pull-ups raise the pin
        for (int b = 0; b < PORT_W; b++) begin
            if (out_buf[24 + b]) begin
                drive_low[24 + b] = ~alt_out[b];
            end else begin
                drive_low[24 + b] = 1'b1;
            end
        end
    end

    // pin outputs: a driven pin carries its level, else released
    always_comb begin
        pin_oe = drive_low | (drive_high & ~drive_low);
        pin_o  = drive_high & ~drive_low;
    end

    // keeper and very weak pull-ups on ports 1..3, never on port 0;
    // the keeper is cut while the nfet pulls the pin down, so the pull-up
    // never fights the driver and draws no static current
    always_comb begin
        pu_keep = keeper & ~drive_low;
        pu_weak = ~drive_low;
        pu_weak[7:0] = 8'h00;
        pu_keep[7:0] = 8'h00;
    end

    // read path: rmw reads the latch, other reads the synced pin;
    // a two-bit port code covers all four ports, so no read can miss
    always_comb begin
        next_rd_data = rd_data;
        if (rd_en) begin
            if (rd_latch) begin
                next_rd_data = port_latch[rd_port*8 +: 8];
            end else begin
                next_rd_data = pin_sync[rd_port*8 +: 8];
            end
        end
        // alternate inputs always see the real port 3 level
        next_alt_in    = pin_sync[31:24];
        next_ext_ad_in = pin_sync[7:0];
    end

    // read results held until the next read request; the core reads
    // rd_data one clock after rd_en, pin reads two clocks staler
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_data   <= 8'h00;
            alt_in    <= 8'hFF;
            ext_ad_in <= 8'hFF;
        end else begin
            rd_data   <= next_rd_data;
            alt_in    <= next_alt_in;
            ext_ad_in <= next_ext_ad_in;
        end
    end
endmodule

/* File: tb/qbp_pin_model.sv */
// qbp_pin_model: external pin loads and pull-downs facing the port block
`timescale 1ns/1ps
module qbp_pin_model (
    input  wire logic        clk,
    input  wire logic [31:0] pin_o,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pu_keep,
    input  wire logic [31:0] pu_weak,
    input  wire logic [31:0] ext_low,  // outside source pulls low
    output      logic [31:0] pin_i
);
    logic flip = 1'b0;  // a floating pin shows a value that changes
    // toggle so an undriven pin never looks like a stable level
    always @(posedge clk) begin
        flip <= ~flip;
    end
    // wire level: block driver, then outside pull-down, then pull-ups
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_low[i]) begin
                pin_i[i] = 1'b0;
            end else if (pu_keep[i] | pu_weak[i]) begin
                pin_i[i] = 1'b1;
            end else begin
                pin_i[i] = flip ^ i[0];  // port zero floats
            end
        end
    end
endmodule

/* File: tb/qbp_port_props.sv */
// qbp_port_props: timing and drive checks on the port block's pins
`timescale 1ns/1ps
module qbp_port_props (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        wr_ready,
    input wire logic        ext_active,
    input wire logic        ext_addr16,
    input wire logic [7:0]  ext_addr_hi,
    input wire logic [7:0]  ext_ad_out,
    input wire logic        ext_ad_oe,
    input wire logic [7:0]  alt_in,
    input wire logic [31:0] pin_i,
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pu_keep,
    input wire logic [31:0] pu_weak
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic s8;  // strong pull-up on port one bit zero
    assign s8 = pin_oe[8] & pin_o[8];
    property p_rdy_width; wr_ready |=> !wr_ready [*8]; endproperty
    a_rdy_width: assert property (p_rdy_width)
        else $error("write slot too wide");
    property p_rdy_period; wr_ready |-> ##12 wr_ready; endproperty
    a_rdy_period: assert property (p_rdy_period)
        else $error("write slot not once per cycle");
    property p_drain; !ext_active |-> (pin_oe[7:0] & pin_o[7:0]) == 8'h00;
    endproperty
    a_drain: assert property (p_drain)
        else $error("port zero drives high as plain port");
    property p_nopull; (pu_keep[7:0] | pu_weak[7:0]) == 8'h00; endproperty
    a_nopull: assert property (p_nopull)
        else $error("port zero has a pull-up");
    property p_bus;
        ext_active && ext_ad_oe |-> pin_oe[7:0] == 8'hFF
            && pin_o[7:0] == ext_ad_out;
    endproperty
    a_bus: assert property (p_bus)
        else $error("port zero not on bus");
    property p_addr;
        ext_active && ext_addr16 |-> pin_oe[23:16] == 8'hFF
            && pin_o[23:16] == ext_addr_hi;
    endproperty
    a_addr: assert property (p_addr)
        else $error("port two not on address");
    property p_weak; pu_weak[31:8] == ~(pin_oe[31:8] & ~pin_o[31:8]);
    endproperty
    a_weak: assert property (p_weak)
        else $error("very weak pull-up wrong");
    property p_pulse_len; $rose(s8) |=> s8 ##1 !s8; endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("strong pulse not two phases");
    property p_pulse_at; $rose(s8) |-> $past(wr_ready, 2); endproperty
    a_pulse_at: assert property (p_pulse_at)
        else $error("strong pulse at wrong slot");
    property p_alt; $stable(pin_i[31:24]) [*5] |-> alt_in == pin_i[31:24];
    endproperty
    a_alt: assert property (p_alt)
        else $error("alternate input not pin level");
endmodule

/* File: tb/test_qbp_port_top.sv */
// test_qbp_port_top: self-checking bench for the port block
`timescale 1ns/1ps
module test_qbp_port_top;
    import qbp_pkg::*;
    logic clk = 0, nrst = 0, wr_en = 0, wr_bit_val = 0, rd_en = 0;
    logic rd_latch = 0, ext_active = 0, ext_addr16 = 0, ext_ad_oe = 0;
    qbp_wr_kind_t wr_kind = QBP_WR_BYTE;
    logic [1:0] wr_port = 0, rd_port = 0;
    logic [2:0] wr_bit = 0;
    logic [7:0] wr_data = 0, ext_addr_hi = 0, ext_ad_out = 0;
    logic [7:0] alt_out = 8'hFF, rd_data, ext_ad_in, alt_in, v;
    logic wr_ready;
    logic [31:0] pin_i, pin_o, pin_oe, pu_keep, pu_weak, ext_low = 0;
    int miscompares = 0, checks_done = 0, cyc = 0;
    qbp_port_top dut (.clk, .nrst, .wr_en, .wr_kind, .wr_port, .wr_data,
        .wr_bit, .wr_bit_val, .wr_ready, .rd_en, .rd_port, .rd_latch,
        .rd_data, .ext_active, .ext_addr16, .ext_addr_hi, .ext_ad_out,
        .ext_ad_oe, .ext_ad_in, .alt_out, .alt_in, .pin_i, .pin_o,
        .pin_oe, .pu_keep, .pu_weak);
    qbp_pin_model pm (.clk, .pin_o, .pin_oe, .pu_keep, .pu_weak,
        .ext_low, .pin_i);
    initial forever #25 clk = ~clk;
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // hold the request until the write slot takes it, then let pins settle
    task automatic wr(input qbp_wr_kind_t k, input logic [1:0] p,
        input logic [7:0] d, input logic [2:0] b, input logic bv);
        int i;
        wr_kind = k; wr_port = p; wr_data = d; wr_bit = b; wr_bit_val = bv;
        wr_en = 1;
        for (i = 0; i < 14; i++) begin
            @(negedge clk);
            if (wr_ready === 1'b1) break;
        end
        if (wr_ready !== 1'b1) miscompares++;
        step(1);
        wr_en = 0;
        step(4);
    endtask
    task automatic rd(input logic [1:0] p, input logic lat);
        rd_port = p; rd_latch = lat; rd_en = 1;
        step(1);
        v = rd_data;
        rd_en = 0;
        step(1);
    endtask
    task automatic t_reset();
        for (int p = 0; p < 4; p++) begin
            rd(2'(p), 1);
            chk(v, LATCH_RST);
        end
        rd(1, 0);
        chk(v, 8'hFF);
        chk(pu_weak[31:8], 24'hFFFFFF);
        $display("reset test done");
    endtask
    task automatic t_port1();
        wr(QBP_WR_BYTE, 1, 8'h00, 0, 0);
        chk({pin_oe[15:8], pin_o[15:8]}, 16'hFF00);
        wr(QBP_WR_BYTE, 1, 8'h5A, 0, 0);
        chk(pu_keep[9], 1'b1);
        rd(1, 0);
        chk(v, 8'h5A);
        ext_low[9] = 1;
        step(4);
        rd(1, 0);
        chk(v, 8'h58);
        rd(1, 1);
        chk(v, 8'h5A);
        chk(pu_keep[9], 1'b0);
        ext_low[9] = 0;
        wr(QBP_WR_BIT, 1, 8'h00, 0, 1);
        rd(1, 1);
        chk(v, 8'h5B);
        wr(QBP_WR_BIT, 1, 8'hFF, 1, 0);
        rd(1, 1);
        chk(v, 8'h59);
        $display("port one test done");
    endtask
    task automatic t_ext();
        wr(QBP_WR_BYTE, 0, 8'h0F, 0, 0);
        chk({pin_oe[7:0], pin_o[7:0]}, 16'hF000);
        wr(QBP_WR_BYTE, 2, 8'h00, 0, 0);
        ext_active = 1; ext_addr16 = 1; ext_addr_hi = 8'hA5;
        ext_ad_out = 8'h3C; ext_ad_oe = 1;
        step(1);
        chk({pin_o[23:16], pin_o[7:0]}, 16'hA53C);
        step(2);
        chk(ext_ad_in, 8'h3C);
        ext_addr16 = 0; ext_ad_oe = 0;
        step(1);
        chk({pin_oe[23:16], pin_o[23:16]}, 16'hFF00);
        chk(pin_oe[7:0], 8'h00);
        ext_active = 0;
        step(1);
        rd(0, 1);
        chk(v, 8'hFF);
        rd(2, 1);
        chk(v, 8'h00);
        $display("external access test done");
    endtask
    task automatic t_port3();
        alt_out = 8'h0F;
        step(2);
        chk(pin_oe[31:24], 8'hF0);
        alt_out = 8'hFF;
        step(2);
        chk(pin_oe[31:24], 8'h00);
        wr(QBP_WR_BYTE, 3, 8'h0F, 0, 0);
        chk(pin_oe[31:24], 8'hF0);
        chk(alt_in, 8'h0F);
        $display("port three test done");
    endtask
    initial begin
        step(2);
        nrst = 1;
        t_reset();
        t_port1();
        t_ext();
        t_port3();
        results();
    end
endmodule
bind qbp_port_top qbp_port_props u_props (.clk, .nrst, .wr_ready,
    .ext_active, .ext_addr16, .ext_addr_hi, .ext_ad_out, .ext_ad_oe,
    .alt_in, .pin_i, .pin_o, .pin_oe, .pu_keep, .pu_weak);
